/* core/cbl_ctl.sv */
`timescale 1ns/1ps
// Controller end: shadow bank tracking and legal command issue
module cbl_ctl (
	input wire logic clk_sys,
	input wire logic rstn,
	cbl_link_if.ctl link,
	input wire logic req_valid,
	input cbl_pkg::cbl_cmd_t req_cmd,
	input wire logic [cbl_pkg::CBL_BANK_W-1:0] req_bank,
	input wire logic req_ap,
	input wire logic req_all,
	output logic req_ack,
	output logic req_nak
);
	import cbl_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		cbl_cmd_t cmd;
		logic [CBL_BANK_W-1:0] bank;
		logic ap;
		logic all_banks;
		logic ack;
		logic nak;
		logic powered;
		logic [CBL_BANKS-1:0] open;
		logic [CBL_BANKS-1:0][CBL_TMR_W-1:0] btmr;
		logic [CBL_TMR_W-1:0] mr;
		logic [CBL_TMR_W-1:0] rrd;
		logic [CBL_TMR_W-1:0] init;
		logic [CBL_TMR_W-1:0] burst;
		logic burst_wr;
		logic [CBL_BANK_W-1:0] owner;
	} cbl_ctl_state_t;

	cbl_ctl_state_t r;
	cbl_ctl_state_t next_r;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic all_idle;
		logic settled;
		logic ok;
		next_r = r;
		all_idle = r.powered && r.init == '0 && r.open == '0 && r.burst == '0;
		settled = 1'b1;
		for (int b = 0; b < CBL_BANKS; b++) begin
			if (r.btmr[b] != '0) begin
				next_r.btmr[b] = r.btmr[b] - 1'b1;
				all_idle = 1'b0;
				settled = 1'b0;
			end
		end
		if (r.mr != '0) next_r.mr = r.mr - 1'b1;
		if (r.rrd != '0) next_r.rrd = r.rrd - 1'b1;
		if (r.init != '0) next_r.init = r.init - 1'b1;
		if (r.burst != '0) next_r.burst = r.burst - 1'b1;
		next_r.cmd = CBL_CMD_NOP;
		next_r.ack = 1'b0;
		next_r.nak = 1'b0;
		ok = 1'b0;
		// Quiet link while a register access runs
		if (req_valid && r.mr == '0) begin
			case (req_cmd)
				CBL_CMD_ACT: ok = r.powered && r.init == '0 && !r.open[req_bank] &&
					r.btmr[req_bank] == '0 && r.rrd <= CBL_TMR_W'(1);
				CBL_CMD_RD: ok = r.open[req_bank] && r.btmr[req_bank] == '0 &&
					!(r.burst != '0 && r.burst_wr);
				CBL_CMD_WR: ok = r.open[req_bank] && r.btmr[req_bank] == '0 &&
					!(r.burst != '0 && !r.burst_wr);
				CBL_CMD_PRE: ok = r.powered && r.init == '0 &&
					(req_all ? settled : r.btmr[req_bank] == '0);
				CBL_CMD_MRR: ok = r.powered && r.burst == '0;
				CBL_CMD_MRW, CBL_CMD_REF: ok = all_idle;
				CBL_CMD_RESET: ok = (all_idle || !r.powered) && r.burst == '0;
				// An auto precharge burst closes its bank and cannot be cut
				CBL_CMD_BST: ok = r.burst != '0 && r.open[r.owner];
				default: ok = 1'b0;
			endcase
			next_r.ack = ok;
			next_r.nak = !ok;
		end
		if (ok) begin
			next_r.cmd = req_cmd;
			next_r.bank = req_bank;
			next_r.ap = req_ap;
			next_r.all_banks = req_all;
			case (req_cmd)
				CBL_CMD_ACT: begin
					next_r.open[req_bank] = 1'b1;
					next_r.btmr[req_bank] = CBL_C_RCD;
					next_r.rrd = CBL_C_RRD;
				end
				CBL_CMD_RD, CBL_CMD_WR: begin
					next_r.burst = CBL_C_BURST;
					next_r.burst_wr = (req_cmd == CBL_CMD_WR);
					next_r.owner = req_bank;
					// Other banks stay free during auto precharge
					if (req_ap) begin
						next_r.open[req_bank] = 1'b0;
						next_r.btmr[req_bank] = CBL_C_AP;
					end
				end
				CBL_CMD_PRE: begin
					for (int b = 0; b < CBL_BANKS; b++) begin
						if (req_all || req_bank == CBL_BANK_W'(b)) begin
							next_r.open[b] = 1'b0;
							next_r.btmr[b] = CBL_C_RP;
						end
					end
				end
				CBL_CMD_MRR: next_r.mr = CBL_C_MRR;
				CBL_CMD_MRW: next_r.mr = CBL_C_MRW;
				CBL_CMD_RESET: begin
					next_r.powered = 1'b1;
					next_r.init = CBL_C_INIT;
					next_r.mr = CBL_C_MRW;
				end
				CBL_CMD_BST: begin
					next_r.bank = r.owner;
					next_r.burst = '0;
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Clock enable held high throughout
	assign link.cke = 1'b1;
	assign link.cmd = r.cmd;
	assign link.bank = r.bank;
	assign link.ap = r.ap;
	assign link.all_banks = r.all_banks;
	assign req_ack = r.ack;
	assign req_nak = r.nak;

endmodule : cbl_ctl

/* core/cbl_dev.sv */
`timescale 1ns/1ps
// Device end: per-bank state tracking and command acceptance
module cbl_dev (
	input wire logic clk_sys,
	input wire logic rstn,
	cbl_link_if.dev link,
	output cbl_pkg::cbl_bank_vec_t bank_state,
	output logic cmd_illegal,
	output logic burst_busy
);
	import cbl_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic cke_prev;
		cbl_bank_vec_t st;
		logic [CBL_BANKS-1:0][CBL_TMR_W-1:0] tmr;
		logic [CBL_TMR_W-1:0] init;
		logic [CBL_BANK_W-1:0] owner;
		logic [CBL_TMR_W-1:0] burst;
		logic illegal;
		logic busy;
	} cbl_dev_state_t;

	cbl_dev_state_t r;
	cbl_dev_state_t next_r;

	// Bank may take a precharge from here
	function automatic logic cbl_pre_ok(input cbl_bank_st_t s);
		return s == CBL_ST_IDLE || s == CBL_ST_ACTIVE || s == CBL_ST_READING ||
			s == CBL_ST_WRITING || s == CBL_ST_PRECHARGING;
	endfunction : cbl_pre_ok

	// Bank holds an open row, idle or in a burst without auto precharge
	function automatic logic cbl_col_ok(input cbl_bank_st_t s);
		return s == CBL_ST_ACTIVE || s == CBL_ST_READING || s == CBL_ST_WRITING;
	endfunction : cbl_col_ok

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic all_idle;
		logic all_pwr;
		logic reg_busy;
		logic mr_block;
		logic pre_all_ok;
		logic [CBL_BANK_W-1:0] bk;
		next_r = r;
		all_idle = 1'b1;
		all_pwr = 1'b1;
		reg_busy = 1'b0;
		mr_block = 1'b0;
		pre_all_ok = 1'b1;
		bk = link.bank;
		next_r.cke_prev = link.cke;
		next_r.illegal = 1'b0;
		// Summaries across banks, taken from the current state
		for (int b = 0; b < CBL_BANKS; b++) begin
			if (r.st[b] != CBL_ST_IDLE) all_idle = 1'b0;
			if (r.st[b] != CBL_ST_POWER_ON) all_pwr = 1'b0;
			if (!cbl_pre_ok(r.st[b])) pre_all_ok = 1'b0;
			// Register access blocks activates and register reads; a burst only blocks register reads
			case (r.st[b])
				CBL_ST_IDLE_MRR, CBL_ST_ACTIVE_MRR, CBL_ST_RESETTING_MRR, CBL_ST_MR_WRITING: begin
					reg_busy = 1'b1;
					mr_block = 1'b1;
				end
				CBL_ST_READING, CBL_ST_WRITING: mr_block = 1'b1;
				default: ;
			endcase
		end
		// Per-bank timers; each bank settles on its own
		for (int b = 0; b < CBL_BANKS; b++) begin
			if (r.tmr[b] != '0) next_r.tmr[b] = r.tmr[b] - 1'b1;
			if (r.tmr[b] == CBL_TMR_W'(1)) begin
				case (r.st[b])
					CBL_ST_ACTIVATING: next_r.st[b] = CBL_ST_ACTIVE;
					CBL_ST_PRECHARGING: next_r.st[b] = CBL_ST_IDLE;
					CBL_ST_READ_AP, CBL_ST_WRITE_AP: next_r.st[b] = CBL_ST_IDLE;
					CBL_ST_IDLE_MRR: next_r.st[b] = CBL_ST_IDLE;
					CBL_ST_ACTIVE_MRR: next_r.st[b] = CBL_ST_ACTIVE;
					CBL_ST_MR_WRITING: next_r.st[b] = CBL_ST_IDLE;
					CBL_ST_RESETTING_MRR: next_r.st[b] = CBL_ST_RESETTING;
					default: ;
				endcase
			end
			// Leave on the last count, in step with the controller's own init count
			if (r.st[b] == CBL_ST_RESETTING && r.init <= CBL_TMR_W'(1)) next_r.st[b] = CBL_ST_IDLE;
		end
		if (r.init != '0) next_r.init = r.init - 1'b1;
		// Natural end of a burst without auto precharge
		if (r.burst != '0) next_r.burst = r.burst - 1'b1;
		if (r.burst == CBL_TMR_W'(1) &&
			(r.st[r.owner] == CBL_ST_READING || r.st[r.owner] == CBL_ST_WRITING)) begin
			next_r.st[r.owner] = CBL_ST_ACTIVE;
		end
		// Commands count only on two high clock enable edges
		if (r.cke_prev && link.cke) begin
			case (link.cmd)
				CBL_CMD_NOP: ;
				CBL_CMD_ACT: begin
					// The target must be idle and no bank may be in a register access
					if (r.st[bk] == CBL_ST_IDLE && !reg_busy) begin
						next_r.st[bk] = CBL_ST_ACTIVATING;
						next_r.tmr[bk] = CBL_C_RCD;
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				CBL_CMD_RD, CBL_CMD_WR: begin
					if (cbl_col_ok(r.st[bk])) begin
						// A new burst ends the previous one on a shared data bus
						if (bk != r.owner &&
							(r.st[r.owner] == CBL_ST_READING || r.st[r.owner] == CBL_ST_WRITING)) begin
							next_r.st[r.owner] = CBL_ST_ACTIVE;
						end
						if (link.ap) begin
							next_r.st[bk] = (link.cmd == CBL_CMD_RD) ? CBL_ST_READ_AP : CBL_ST_WRITE_AP;
							next_r.tmr[bk] = CBL_C_AP;
						end else begin
							next_r.st[bk] = (link.cmd == CBL_CMD_RD) ? CBL_ST_READING : CBL_ST_WRITING;
							next_r.tmr[bk] = '0;
						end
						next_r.owner = bk;
						next_r.burst = CBL_C_BURST;
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				CBL_CMD_PRE: begin
					if (link.all_banks) begin
						if (pre_all_ok) begin
							for (int b = 0; b < CBL_BANKS; b++) begin
								next_r.st[b] = CBL_ST_PRECHARGING;
								next_r.tmr[b] = CBL_C_RP;
							end
						end else begin
							next_r.illegal = 1'b1;
						end
					end else if (cbl_pre_ok(r.st[bk])) begin
						next_r.st[bk] = CBL_ST_PRECHARGING;
						next_r.tmr[bk] = CBL_C_RP;
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				CBL_CMD_MRR: begin
					if (!mr_block) begin
						// Activating and precharging banks keep counting
						for (int b = 0; b < CBL_BANKS; b++) begin
							case (r.st[b])
								CBL_ST_IDLE: begin
									next_r.st[b] = CBL_ST_IDLE_MRR;
									next_r.tmr[b] = CBL_C_MRR;
								end
								CBL_ST_ACTIVE: begin
									next_r.st[b] = CBL_ST_ACTIVE_MRR;
									next_r.tmr[b] = CBL_C_MRR;
								end
								CBL_ST_RESETTING: begin
									next_r.st[b] = CBL_ST_RESETTING_MRR;
									next_r.tmr[b] = CBL_C_MRR;
								end
								default: ;
							endcase
						end
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				CBL_CMD_MRW: begin
					if (all_idle) begin
						for (int b = 0; b < CBL_BANKS; b++) begin
							next_r.st[b] = CBL_ST_MR_WRITING;
							next_r.tmr[b] = CBL_C_MRW;
						end
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				CBL_CMD_RESET: begin
					// Device-wide, never bank specific
					if (all_idle || all_pwr) begin
						for (int b = 0; b < CBL_BANKS; b++) begin
							next_r.st[b] = CBL_ST_RESETTING;
							next_r.tmr[b] = '0;
						end
						next_r.init = CBL_C_INIT;
						next_r.burst = '0;
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				CBL_CMD_REF: begin
					// Refresh timing itself is not modelled here
					if (!all_idle) next_r.illegal = 1'b1;
				end
				CBL_CMD_BST: begin
					// Bank field ignored: the running burst is the target
					if (r.burst != '0 &&
						(r.st[r.owner] == CBL_ST_READING || r.st[r.owner] == CBL_ST_WRITING)) begin
						next_r.st[r.owner] = CBL_ST_ACTIVE;
						next_r.burst = '0;
					end else begin
						next_r.illegal = 1'b1;
					end
				end
				default: next_r.illegal = 1'b1;
			endcase
		end
		next_r.busy = (next_r.burst != '0);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r.cke_prev <= 1'b0;
			r.st <= cbl_bank_vec_t'({CBL_BANKS{CBL_ST_POWER_ON}});
			r.tmr <= '0;
			r.init <= '0;
			r.owner <= '0;
			r.burst <= '0;
			r.illegal <= 1'b0;
			r.busy <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign bank_state = r.st;
	assign cmd_illegal = r.illegal;
	assign burst_busy = r.busy;

endmodule : cbl_dev

/* inc/cbl_link_if.sv */
`timescale 1ns/1ps
// Command and address link between controller and device
interface cbl_link_if;
	import cbl_pkg::*;
	logic cke;
	cbl_cmd_t cmd;
	logic [CBL_BANK_W-1:0] bank;
	logic ap;
	logic all_banks;

	modport ctl (
		output cke,
		output cmd,
		output bank,
		output ap,
		output all_banks
	);

	modport dev (
		input cke,
		input cmd,
		input bank,
		input ap,
		input all_banks
	);
endinterface : cbl_link_if

/* inc/cbl_pkg.sv */
// Behaviour
// - Commands count only with clock enable high twice
// - Undefined state and command pairs are never issued
// - No-operation leaves every bank state unchanged
// - Idle bank never restricts commands to others
// - Keep row-to-row delay between activates
// - Read or write moves open bank to burst
// - Precharge one or all banks, all valid
// - Register read accepted while activating or precharging
// - Banks settle after register read by state
// - Only no-operation during register read or write
// - Refresh and register write need all idle
// - Burst terminate hits bursting bank, back active
// - Burst terminate only while burst runs
// - Write after read needs completion or terminate
// - Read after write needs completion or terminate
// - Auto precharge leaves other banks free
// - Reset by register write starts self-initialization
// - Register read while resetting, then back
// - Idle after precharge time, active after activate
// - Burst state holds until completion or terminate; the device also ends it on a new burst to another bank or a precharge
package cbl_pkg;

	// ****************************************
	// Geometry and timing
	// ****************************************
	localparam int CBL_BANKS = 8;
	localparam int CBL_BANK_W = 3;
	localparam int CBL_TMR_W = 8;
	localparam int CBL_CLK_MHZ = 200;
	localparam int CBL_T_RCD_NS = 18;
	localparam int CBL_T_RP_NS = 18;
	localparam int CBL_T_RRD_NS = 10;
	localparam int CBL_T_MRR_NS = 10;
	localparam int CBL_T_MRW_NS = 10;
	localparam int CBL_T_INIT_NS = 1000;
	localparam int CBL_BURST_CYCLES = 4;

	// Least time to whole cycles, never below one
	function automatic int cbl_cyc(input int ns);
		int c;
		c = (ns * CBL_CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cbl_cyc

	localparam logic [CBL_TMR_W-1:0] CBL_C_RCD = CBL_TMR_W'(cbl_cyc(CBL_T_RCD_NS));
	localparam logic [CBL_TMR_W-1:0] CBL_C_RP = CBL_TMR_W'(cbl_cyc(CBL_T_RP_NS));
	localparam logic [CBL_TMR_W-1:0] CBL_C_RRD = CBL_TMR_W'(cbl_cyc(CBL_T_RRD_NS));
	localparam logic [CBL_TMR_W-1:0] CBL_C_MRR = CBL_TMR_W'(cbl_cyc(CBL_T_MRR_NS));
	localparam logic [CBL_TMR_W-1:0] CBL_C_MRW = CBL_TMR_W'(cbl_cyc(CBL_T_MRW_NS));
	localparam logic [CBL_TMR_W-1:0] CBL_C_INIT = CBL_TMR_W'(cbl_cyc(CBL_T_INIT_NS));
	localparam logic [CBL_TMR_W-1:0] CBL_C_BURST = CBL_TMR_W'(CBL_BURST_CYCLES);
	localparam logic [CBL_TMR_W-1:0] CBL_C_AP = CBL_TMR_W'(CBL_BURST_CYCLES + cbl_cyc(CBL_T_RP_NS));

	// ****************************************
	// Commands and bank states
	// ****************************************
	typedef enum logic [3:0] {
		CBL_CMD_NOP = 4'h0,
		CBL_CMD_ACT = 4'h1,
		CBL_CMD_RD = 4'h2,
		CBL_CMD_WR = 4'h3,
		CBL_CMD_PRE = 4'h4,
		CBL_CMD_MRR = 4'h5,
		CBL_CMD_MRW = 4'h6,
		CBL_CMD_RESET = 4'h7, // Register write to the reset address
		CBL_CMD_REF = 4'h8,
		CBL_CMD_BST = 4'h9
	} cbl_cmd_t;

	typedef enum logic [3:0] {
		CBL_ST_POWER_ON = 4'h0,
		CBL_ST_IDLE = 4'h1,
		CBL_ST_ACTIVATING = 4'h2,
		CBL_ST_ACTIVE = 4'h3,
		CBL_ST_READING = 4'h4,
		CBL_ST_WRITING = 4'h5,
		CBL_ST_READ_AP = 4'h6,
		CBL_ST_WRITE_AP = 4'h7,
		CBL_ST_PRECHARGING = 4'h8,
		CBL_ST_IDLE_MRR = 4'h9,
		CBL_ST_ACTIVE_MRR = 4'hA,
		CBL_ST_MR_WRITING = 4'hB,
		CBL_ST_RESETTING = 4'hC,
		CBL_ST_RESETTING_MRR = 4'hD
	} cbl_bank_st_t;

	typedef cbl_bank_st_t [CBL_BANKS-1:0] cbl_bank_vec_t;

endpackage : cbl_pkg

/* verification/cbl_link_assertions.sv */
`timescale 1ns/1ps
// Watches the link between the two ends and the device's view of it
module cbl_link_assertions (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cke,
	input cbl_pkg::cbl_cmd_t cmd,
	input wire logic [cbl_pkg::CBL_BANK_W-1:0] bank,
	input wire logic ap,
	input wire logic all_banks,
	input cbl_pkg::cbl_bank_vec_t bank_state,
	input wire logic cmd_illegal,
	input wire logic burst_busy
);
	import cbl_pkg::*;
	logic seen_cmd;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// ****************************************
	// Helper logic
	// ****************************************
	// First command after reset must be the reset itself
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			seen_cmd <= 1'b0;
		else if (cmd != CBL_CMD_NOP)
			seen_cmd <= 1'b1;
	end

	// ****************************************
	// Properties
	// ****************************************
	property p_cke_high;
		cke == 1'b1;
	endproperty
	a_cke_high: assert property (p_cke_high) else $error("clock enable dropped");
	property p_act_gap;
		cmd == CBL_CMD_ACT |=> cmd != CBL_CMD_ACT;
	endproperty
	a_act_gap: assert property (p_act_gap) else $error("activates too close");
	property p_mrr_quiet;
		cmd == CBL_CMD_MRR |=> cmd == CBL_CMD_NOP;
	endproperty
	a_mrr_quiet: assert property (p_mrr_quiet) else $error("command during register read");
	property p_mrw_quiet;
		cmd inside {CBL_CMD_MRW, CBL_CMD_RESET} |=> cmd == CBL_CMD_NOP;
	endproperty
	a_mrw_quiet: assert property (p_mrw_quiet) else $error("command during register write");
	property p_no_illegal;
		!cmd_illegal;
	endproperty
	a_no_illegal: assert property (p_no_illegal) else $error("controller sent a refused command");
	property p_bst_busy;
		cmd == CBL_CMD_BST |-> burst_busy;
	endproperty
	a_bst_busy: assert property (p_bst_busy) else $error("terminate without a burst");
	property p_first_reset;
		!seen_cmd && cmd != CBL_CMD_NOP |-> cmd == CBL_CMD_RESET;
	endproperty
	a_first_reset: assert property (p_first_reset) else $error("first command not reset");
	property p_rd_state;
		cmd == CBL_CMD_RD && !ap |=> bank_state[$past(bank)] == CBL_ST_READING;
	endproperty
	a_rd_state: assert property (p_rd_state) else $error("read did not start burst");
endmodule : cbl_link_assertions

/* verification/cross_bank_command_legality_tb.sv */
`timescale 1ns/1ps
// Drives the controller's request port and watches the device end
module cross_bank_command_legality_tb;
	import cbl_pkg::*;
	logic clk_sys;
	logic rstn;
	logic req_valid;
	cbl_cmd_t req_cmd;
	logic [CBL_BANK_W-1:0] req_bank;
	logic req_ap;
	logic req_all;
	logic req_ack;
	logic req_nak;
	logic cmd_illegal;
	logic burst_busy;
	logic flt_illegal;
	cbl_bank_vec_t bank_state;
	cbl_bank_vec_t flt_state;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	cbl_link_if link ();
	cbl_link_if flt_link ();

	cbl_ctl cbl_ctl_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link.ctl), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_bank(req_bank), .req_ap(req_ap), .req_all(req_all),
		.req_ack(req_ack), .req_nak(req_nak));
	cbl_dev cbl_dev_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link.dev), .bank_state(bank_state),
		.cmd_illegal(cmd_illegal), .burst_busy(burst_busy));
	// Second device fed by the bench, to break link rules on purpose
	cbl_dev cbl_dev_inst2 (.clk_sys(clk_sys), .rstn(rstn), .link(flt_link.dev), .bank_state(flt_state),
		.cmd_illegal(flt_illegal), .burst_busy());
	cbl_link_assertions cbl_link_assertions_inst (.clk_sys(clk_sys), .rstn(rstn), .cke(link.cke),
		.cmd(link.cmd), .bank(link.bank), .ap(link.ap), .all_banks(link.all_banks),
		.bank_state(bank_state), .cmd_illegal(cmd_illegal), .burst_busy(burst_busy));

	// ****************************************
	// Clock and hang guard
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Whole run is under a thousand cycles
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			conclude();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	// One request; the one-cycle answer is checked while it still stands
	task automatic issue(input cbl_cmd_t c, input int b, input logic a, input logic ok);
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = CBL_BANK_W'(b);
		req_ap = a & (c != CBL_CMD_PRE);
		req_all = a & (c == CBL_CMD_PRE);
		tick(1);
		chk("req_ack", {3'h0, ok}, {3'h0, req_ack});
		chk("req_nak", {3'h0, !ok}, {3'h0, req_nak});
		req_valid = 1'b0;
		tick(1);
	endtask : issue

	task automatic st_all(input cbl_bank_st_t e);
		for (int i = 0; i < CBL_BANKS; i++) begin
			chk("bank_state", e, bank_state[i]);
		end
	endtask : st_all

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req_cmd = CBL_CMD_NOP;
		req_bank = 3'h0;
		req_ap = 1'b0;
		req_all = 1'b0;
		flt_link.cke = 1'b0;
		flt_link.cmd = CBL_CMD_RESET;
		flt_link.bank = 3'h0;
		flt_link.ap = 1'b0;
		flt_link.all_banks = 1'b0;
		tick(16);
		rstn = 1'b1;
		tick(2);
		chk("fault bank", CBL_ST_POWER_ON, flt_state[0]);
		flt_link.cke = 1'b1;
		flt_link.cmd = CBL_CMD_NOP;
		tick(1);
		flt_link.cmd = CBL_CMD_BST;
		tick(1);
		flt_link.cmd = CBL_CMD_NOP;
		chk("fault flag", 4'h1, {3'h0, flt_illegal});
		issue(CBL_CMD_ACT, 1, 1'b0, 1'b0);
		issue(CBL_CMD_RESET, 0, 1'b0, 1'b1);
		tick(1);
		st_all(CBL_ST_RESETTING);
		tick(2);
		issue(CBL_CMD_MRR, 0, 1'b0, 1'b1);
		tick(1);
		chk("bank 0", CBL_ST_RESETTING_MRR, bank_state[0]);
		tick(3);
		chk("bank 0", CBL_ST_RESETTING, bank_state[0]);
		issue(CBL_CMD_ACT, 1, 1'b0, 1'b0);
		tick(200);
		st_all(CBL_ST_IDLE);
		issue(CBL_CMD_ACT, 1, 1'b0, 1'b1);
		issue(CBL_CMD_ACT, 2, 1'b0, 1'b1);
		issue(CBL_CMD_MRR, 3, 1'b0, 1'b1);
		tick(1);
		chk("bank 3", CBL_ST_IDLE_MRR, bank_state[3]);
		tick(5);
		chk("bank 1", CBL_ST_ACTIVE, bank_state[1]);
		chk("bank 2", CBL_ST_ACTIVE, bank_state[2]);
		chk("bank 3", CBL_ST_IDLE, bank_state[3]);
		// Read, terminate, then a write refused while a read runs
		issue(CBL_CMD_RD, 1, 1'b0, 1'b1);
		tick(1);
		chk("bank 1", CBL_ST_READING, bank_state[1]);
		chk("burst_busy", 4'h1, {3'h0, burst_busy});
		issue(CBL_CMD_BST, 5, 1'b0, 1'b1);
		tick(1);
		chk("bank 1", CBL_ST_ACTIVE, bank_state[1]);
		issue(CBL_CMD_RD, 1, 1'b0, 1'b1);
		issue(CBL_CMD_WR, 2, 1'b0, 1'b0);
		tick(4);
		chk("bank 1", CBL_ST_ACTIVE, bank_state[1]);
		issue(CBL_CMD_BST, 1, 1'b0, 1'b0);
		issue(CBL_CMD_WR, 2, 1'b0, 1'b1);
		issue(CBL_CMD_RD, 1, 1'b0, 1'b0);
		tick(4);
		// Auto precharge on one bank leaves the others free
		issue(CBL_CMD_RD, 1, 1'b1, 1'b1);
		issue(CBL_CMD_RD, 2, 1'b0, 1'b1);
		tick(1);
		chk("bank 1", CBL_ST_READ_AP, bank_state[1]);
		chk("bank 2", CBL_ST_READING, bank_state[2]);
		tick(8);
		chk("bank 1", CBL_ST_IDLE, bank_state[1]);
		issue(CBL_CMD_MRW, 0, 1'b0, 1'b0);
		issue(CBL_CMD_PRE, 0, 1'b1, 1'b1);
		issue(CBL_CMD_MRR, 2, 1'b0, 1'b1);
		tick(5);
		st_all(CBL_ST_IDLE);
		issue(CBL_CMD_MRW, 0, 1'b0, 1'b1);
		tick(3);
		issue(CBL_CMD_REF, 0, 1'b0, 1'b1);
		tick(2);
		st_all(CBL_ST_IDLE);
		conclude();
	end
endmodule : cross_bank_command_legality_tb
